/* hw/srr_pkg.sv */
package srr_pkg;
  // ----------------------------------------
  // frame layout
  // ----------------------------------------
  localparam int          FRAME_BITS    = 32;
  localparam int          CMD_MSB       = 31;
  localparam int          CMD_LSB       = 28;
  localparam int          ADDR_MSB      = 23;
  localparam int          ADDR_LSB      = 17;
  localparam logic [3:0]  CMD_REG_READ  = 4'hc;
  localparam logic [3:0]  RSP_REG_READ  = 4'h6;
  localparam logic [1:0]  BASIC_OK      = 2'h0;
  localparam logic [1:0]  BASIC_ERROR   = 2'h3;
  localparam logic [3:0]  CMD_NO_DATA   = 4'h0;
  localparam logic [31:0] FRAME_RESET   = 32'h0000_0000;
  localparam logic [5:0]  BITCNT_RESET  = 6'h00;
  // sclk low, cs_n high, mosi low: the idle pins
  localparam logic [2:0]  PINS_RESET    = 3'h2;

  // ----------------------------------------
  // response word
  // ----------------------------------------
  // payload is {00, high byte, low byte} for data, {16 zeros, detail status} for errors
  typedef struct packed {
    logic [3:0]  cmd;
    logic [1:0]  basic_status_field;
    logic [17:0] payload;
    logic [7:0]  crc;
  } srr_rsp_t;

  typedef struct packed {
    logic       sclk;
    logic       cs_n;
    logic       mosi;
  } srr_pins_t;
endpackage

/* hw/srr_spi_read.sv */
`timescale 1ns/1ns
// How it works
// - frames are 32 bits, shifted msb first, bit 31 leads.
// - read uses byte address bits 7:1 to pick a pair of 8-bit registers.
// - read data goes out next frame only with no framing or output error.
// - on either error the next frame carries the error word instead.
// - register values are captured when chip select rises.
// - sensor response order: command, status, value, resolution, detail, crc.
// - error word has status 11, data 0000, detail status and crc at end.
// - good read response carries command field 0110.
// - odd byte register goes in upper data byte, even in lower.
module srr_spi_read
  import srr_pkg::*;
#(
  parameter int ADDR_W = 7
) (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic              spi_sclk,
  input  wire logic              spi_cs_n,
  input  wire logic              spi_mosi,
  output logic                   spi_miso,
  output logic                   spi_miso_oe,
  output logic [ADDR_W:0]        reg_addr,
  input  wire logic [15:0]       reg_pair,
  input  wire logic              frame_err,
  input  wire logic              miso_err,
  input  wire logic [1:0]        detail_status,
  input  wire logic [7:0]        rsp_crc,
  output logic                   frame_done
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  srr_pins_t s1_q, s2_q, s3_q;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      // idle pin levels, so the edge detectors see no false edge after reset
      s1_q <= srr_pins_t'(PINS_RESET);
      s2_q <= srr_pins_t'(PINS_RESET);
      s3_q <= srr_pins_t'(PINS_RESET);
    end else begin
      s1_q <= '{spi_sclk, spi_cs_n, spi_mosi};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  logic rise, fall, cs_rise, cs_fall;
  assign rise    = s2_q.sclk & ~s3_q.sclk & ~s2_q.cs_n;
  assign fall    = ~s2_q.sclk & s3_q.sclk & ~s2_q.cs_n;
  assign cs_rise = s2_q.cs_n & ~s3_q.cs_n;
  assign cs_fall = ~s2_q.cs_n & s3_q.cs_n;

  // ----------------------------------------
  // shift state
  // ----------------------------------------
  typedef enum logic [0:0] {SRR_IDLE = 1'b0, SRR_SHIFT = 1'b1} srr_state_t;
  srr_state_t       st_q, st_d;
  logic [31:0]      rx_q, rx_d, tx_q, tx_d, next_q, next_d;
  logic [5:0]       cnt_q, cnt_d;
  logic             miso_q, miso_d, oe_q, oe_d, done_q, done_d;
  logic [ADDR_W:0]  addr_q, addr_d;
  srr_rsp_t         rsp;
  logic             good;
  logic [3:0]       cmd_field;
  logic [ADDR_W-1:0] word_addr;
  logic             sensor_req;

  assign cmd_field  = rx_q[CMD_MSB:CMD_LSB];
  assign word_addr  = rx_q[ADDR_MSB:ADDR_LSB];
  // odd command codes ask for sensor data, which this block never holds
  assign sensor_req = cmd_field[0];

  always_comb begin
    st_d   = st_q;
    rx_d   = rx_q;
    tx_d   = tx_q;
    next_d = next_q;
    cnt_d  = cnt_q;
    miso_d = miso_q;
    oe_d   = oe_q;
    done_d = 1'b0;
    addr_d = addr_q;
    good   = (cmd_field == CMD_REG_READ) & ~frame_err & ~miso_err & (cnt_q == 6'd32);
    rsp     = srr_rsp_t'(FRAME_RESET);
    rsp.crc = rsp_crc;
    if (good) begin
      rsp.cmd                = RSP_REG_READ;
      rsp.basic_status_field = BASIC_OK;
      rsp.payload            = {2'b00, reg_pair};
    end else begin
      // same field order as a data word: cmd, status, data, detail, crc
      rsp.cmd                = {rx_q[CMD_LSB], rx_q[CMD_MSB:CMD_LSB+1]};
      if (sensor_req)
        rsp.cmd              = CMD_NO_DATA;
      rsp.basic_status_field = BASIC_ERROR;
      rsp.payload            = {16'h0000, detail_status};
    end
    case (st_q)
      SRR_IDLE: begin
        if (cs_fall) begin
          st_d   = SRR_SHIFT;
          cnt_d  = BITCNT_RESET;
          tx_d   = next_q;
          miso_d = next_q[FRAME_BITS-1];
          oe_d   = 1'b1;
        end
      end
      SRR_SHIFT: begin
        if (rise) begin
          rx_d  = {rx_q[30:0], s2_q.mosi};
          cnt_d = cnt_q + 6'd1;
        end
        if (fall) begin
          tx_d   = {tx_q[30:0], 1'b0};
          miso_d = tx_q[30];
        end
        if (cmd_field == CMD_REG_READ && cnt_q == 6'd32)
          addr_d = {word_addr, 1'b0};
        if (cs_rise) begin
          st_d   = SRR_IDLE;
          oe_d   = 1'b0;
          done_d = 1'b1;
          next_d = rsp;
        end
      end
      default: st_d = SRR_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_q   <= SRR_IDLE;
      rx_q   <= FRAME_RESET;
      tx_q   <= FRAME_RESET;
      next_q <= FRAME_RESET;
      cnt_q  <= BITCNT_RESET;
      miso_q <= 1'b0;
      oe_q   <= 1'b0;
      done_q <= 1'b0;
      addr_q <= '0;
    end else begin
      st_q   <= st_d;
      rx_q   <= rx_d;
      tx_q   <= tx_d;
      next_q <= next_d;
      cnt_q  <= cnt_d;
      miso_q <= miso_d;
      oe_q   <= oe_d;
      done_q <= done_d;
      addr_q <= addr_d;
    end
  end

  assign spi_miso    = miso_q;
  assign spi_miso_oe = oe_q;
  assign reg_addr    = addr_q;
  assign frame_done  = done_q;

  // ----------------------------------------
  // checks on the answer word
  // ----------------------------------------
  AST_GOOD_CMD: assert property (@(posedge sys_clk) disable iff (!resetn)
    (st_q == SRR_SHIFT && cs_rise && good) |=> next_q[31:28] == RSP_REG_READ)
    else $error("read response command not 0110");
  AST_GOOD_STATUS: assert property (@(posedge sys_clk) disable iff (!resetn)
    (st_q == SRR_SHIFT && cs_rise && good) |=> next_q[27:24] == {BASIC_OK, 2'b00})
    else $error("good read status not clear");
  AST_CAPTURE: assert property (@(posedge sys_clk) disable iff (!resetn)
    (st_q == SRR_SHIFT && cs_rise && good) |=> next_q[23:8] == $past(reg_pair))
    else $error("register pair not captured at cs rise");
  AST_GOOD_CRC: assert property (@(posedge sys_clk) disable iff (!resetn)
    (st_q == SRR_SHIFT && cs_rise && good) |=> next_q[7:0] == $past(rsp_crc))
    else $error("read response crc byte lost");
  AST_ERR_STATUS: assert property (@(posedge sys_clk) disable iff (!resetn)
    (st_q == SRR_SHIFT && cs_rise && (frame_err || miso_err)) |=> next_q[27:26] == BASIC_ERROR)
    else $error("error status not 11");
  AST_ERR_DATA: assert property (@(posedge sys_clk) disable iff (!resetn)
    (st_q == SRR_SHIFT && cs_rise && !good) |=> next_q[25:10] == 16'h0000)
    else $error("error data not zero");
  AST_ERR_DETAIL: assert property (@(posedge sys_clk) disable iff (!resetn)
    (st_q == SRR_SHIFT && cs_rise && !good) |=> next_q[9:8] == $past(detail_status) && next_q[7:0] == $past(rsp_crc))
    else $error("error word detail status or crc misplaced");
  AST_ERR_ECHO: assert property (@(posedge sys_clk) disable iff (!resetn)
    (st_q == SRR_SHIFT && cs_rise && !good && !sensor_req) |=> {next_q[30:28], next_q[31]} == $past(cmd_field))
    else $error("error word does not echo the rotated command");
  AST_SENSOR_ERR_CMD: assert property (@(posedge sys_clk) disable iff (!resetn)
    (st_q == SRR_SHIFT && cs_rise && sensor_req) |=> next_q[31:28] == CMD_NO_DATA)
    else $error("sensor request error command not 0000");

  // ----------------------------------------
  // checks on the link side
  // ----------------------------------------
  AST_OE_FOLLOWS_CS: assert property (@(posedge sys_clk) disable iff (!resetn)
    cs_rise |=> !spi_miso_oe)
    else $error("miso enable stays after cs rise");
  AST_OE_IN_FRAME: assert property (@(posedge sys_clk) disable iff (!resetn)
    st_q == SRR_SHIFT |-> spi_miso_oe)
    else $error("miso enable low inside a frame");
  AST_LOAD: assert property (@(posedge sys_clk) disable iff (!resetn)
    (st_q == SRR_IDLE && cs_fall) |=> spi_miso == next_q[FRAME_BITS-1] && spi_miso_oe)
    else $error("first bit not bit 31");
  AST_SHIFT_OUT: assert property (@(posedge sys_clk) disable iff (!resetn)
    (st_q == SRR_SHIFT && fall) |=> spi_miso == tx_q[FRAME_BITS-1])
    else $error("miso not the next bit after sclk fall");
  AST_IDLE_HOLDS: assert property (@(posedge sys_clk) disable iff (!resetn)
    st_q == SRR_IDLE |=> $stable(rx_q))
    else $error("receive word moved outside a frame");
  AST_ADDR: assert property (@(posedge sys_clk) disable iff (!resetn)
    (st_q == SRR_SHIFT && cnt_q == 6'd32 && cmd_field == CMD_REG_READ) |=> reg_addr == {$past(word_addr), 1'b0})
    else $error("register address not taken from the word address field");
  AST_DONE_AFTER_CS: assert property (@(posedge sys_clk) disable iff (!resetn)
    (st_q == SRR_SHIFT && cs_rise) |=> frame_done)
    else $error("frame done missing after cs rise");
  AST_DONE_ONE_CYCLE: assert property (@(posedge sys_clk) disable iff (!resetn)
    frame_done |=> !frame_done)
    else $error("frame done longer than one cycle");

  // ----------------------------------------
  // coverage
  // ----------------------------------------
  COV_READ: cover property (@(posedge sys_clk) disable iff (!resetn) cs_rise && good);
  COV_ERR: cover property (@(posedge sys_clk) disable iff (!resetn) cs_rise && frame_err);
  COV_FRAME: cover property (@(posedge sys_clk) disable iff (!resetn) cs_fall ##[1:1000] cs_rise);
  COV_SENSOR_ERR: cover property (@(posedge sys_clk) disable iff (!resetn) st_q == SRR_SHIFT && cs_rise && sensor_req);
endmodule

/* bench/srr_host.sv */
`timescale 1ns/1ns
module srr_host
  import srr_pkg::*;
(
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  // ----------------------------------------
  // spi host, mode 0, 125 ns link clock
  // ----------------------------------------
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  function automatic logic [31:0] rd_req(input logic [6:0] wa);
    return {CMD_REG_READ, 4'h0, wa, 1'b0, 8'h00, 8'h00};
  endfunction

  // clock stands low between frames; data released to the inverse of its last bit
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    spi_cs_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      spi_mosi = tx[i];
      #60 spi_sclk = 1'b1;
      rx[i] = spi_miso;
      #65 spi_sclk = 1'b0;
    end
    #60 spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    #100;
  endtask
endmodule

/* bench/spi_register_read_and_responses_test.sv */
`timescale 1ns/1ns
module spi_register_read_and_responses_test
  import srr_pkg::*;
;
  logic        sys_clk, resetn, sclk, cs_n, mosi, miso, miso_oe, frame_err, miso_err, frame_done;
  logic [7:0]  reg_addr, rsp_crc;
  logic [15:0] reg_pair;
  logic [1:0]  detail_status;
  int          failures, samples_checked;
  int          done_count = 0;
  int          oe_slips = 0;

  srr_host host (.spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso));
  srr_spi_read DUT (.sys_clk(sys_clk), .resetn(resetn), .spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(miso_oe), .reg_addr(reg_addr),
    .reg_pair(reg_pair), .frame_err(frame_err), .miso_err(miso_err),
    .detail_status(detail_status), .rsp_crc(rsp_crc), .frame_done(frame_done));

  always #5 sys_clk = ~sys_clk;

  // frame done pulses, and sclk rises seen without miso enabled
  always @(posedge sys_clk) begin
    if (frame_done === 1'b1)
      done_count <= done_count + 1;
  end
  always @(posedge sclk) begin
    if (miso_oe !== 1'b1)
      oe_slips <= oe_slips + 1;
  end

  // ----------------------------------------
  // checking and scenarios
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // register pair changes after the request frame; the answer must keep the old one
  task automatic read_ok(input logic [6:0] wa, input logic [15:0] pair);
    logic [31:0] rx;
    int          n;
    n = done_count;
    @(negedge sys_clk);
    reg_pair = pair;
    host.xfer(host.rd_req(wa), rx);
    check({24'h0, reg_addr}, {24'h0, wa, 1'b0});
    check(done_count, n + 1);
    check({30'h0, frame_done, miso_oe}, 32'h0);
    @(negedge sys_clk);
    reg_pair = ~pair;
    host.xfer(host.rd_req(wa), rx);
    check(rx, {RSP_REG_READ, BASIC_OK, 2'b00, pair, rsp_crc});
    check(oe_slips, 32'h0);
    $display("read_ok %h done", wa);
  endtask

  // sensor requests cannot be served here, so their error word carries command 0000
  task automatic read_err(input logic [3:0] cmd, input logic fe, input logic me);
    logic [31:0] rx;
    logic [3:0]  exp_cmd;
    exp_cmd = cmd[0] ? CMD_NO_DATA : {cmd[0], cmd[3:1]};
    @(negedge sys_clk);
    frame_err = fe;
    miso_err = me;
    host.xfer({cmd, 4'h0, 7'h15, 1'b0, 16'h0000}, rx);
    @(negedge sys_clk);
    frame_err = 1'b0;
    miso_err = 1'b0;
    host.xfer(host.rd_req(7'h15), rx);
    check(rx, {exp_cmd, BASIC_ERROR, 16'h0000, detail_status, rsp_crc});
    $display("read_err %h done", cmd);
  endtask

  // a reset between frames drops the pending answer and the held address
  task automatic reset_mid;
    logic [31:0] rx;
    @(negedge sys_clk);
    resetn = 1'b0;
    repeat (10) @(negedge sys_clk);
    resetn = 1'b1;
    check({24'h0, reg_addr}, 32'h0);
    check({31'h0, miso_oe}, 32'h0);
    repeat (3) @(negedge sys_clk);
    host.xfer(host.rd_req(7'h33), rx);
    check(rx, FRAME_RESET);
    $display("reset_mid done");
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    resetn = 1'b0;
    reg_pair = 16'h0000;
    frame_err = 1'b0;
    miso_err = 1'b0;
    detail_status = 2'h2;
    rsp_crc = 8'hc3;
    failures = 0;
    samples_checked = 0;
    repeat (10) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (3) @(negedge sys_clk);
    read_ok(7'h00, 16'ha55a);
    read_ok(7'h7f, 16'h3cc3);
    read_err(CMD_REG_READ, 1'b1, 1'b0);
    detail_status = 2'h1;
    rsp_crc = 8'h5e;
    read_err(CMD_REG_READ, 1'b0, 1'b1);
    read_err(4'he, 1'b0, 1'b0);
    read_err(4'h3, 1'b0, 1'b0);
    read_ok(7'h2a, 16'h8001);
    reset_mid();
    tally_and_finish();
  end
endmodule
